/* hdl/cmd_frame_parser.sv */
// command frame receiver and reply sequencer for a slave motion module
`timescale 1ns/1ns
`default_nettype none
module cmd_frame_parser
	import frame_pkg::*;
(
	input  wire logic  clock,		// system clock, 25 MHz
	input  wire logic  nrst,		// async reset, active low
	input  wire logic  can_mode,		// short form link
	input  wire byte_t module_address,	// our address
	input  wire byte_t reply_address,	// address the host listens on
	input  wire logic  rx_valid,		// incoming byte valid
	input  wire byte_t rx_data,		// incoming byte
	output logic       rx_ready,		// parser takes rx_data
	output logic       exec_valid,		// command waits for executor
	output byte_t      exec_code,		// command code
	output byte_t      exec_type,		// type field
	output byte_t      exec_bank,		// motor or bank selector
	output word_t      exec_value,		// four-byte value
	input  wire logic  exec_ready,		// executor takes the command
	input  wire logic  result_valid,	// executor finished
	input  wire byte_t result_status,	// status to report
	input  wire word_t result_value,	// value to report
	output logic       tx_valid,		// reply byte valid
	output byte_t      tx_data,		// reply byte
	input  wire logic  tx_ready,		// link takes the reply byte
	output logic       tx_last,		// final reply byte
	output logic       tx_drive		// bus driver enable
);
	typedef enum logic [1:0] {
		S_RECV,		// listening for a command
		S_EXEC,		// offering the command to the executor
		S_WAIT,		// waiting for the executor's result
		S_REPLY		// reply in flight
	} state_t;

	state_t state;		// sequencer state
	idx_t   idx;		// position of the next incoming byte
	idx_t   first_idx;	// first byte position for this form
	idx_t   last_idx;	// final byte position for this form
	byte_t  sum;		// running 8-bit sum of command bytes
	logic   addr_hit;	// address byte matched this module
	logic   rx_take;	// byte accepted this cycle
	logic   frame_end;	// last byte of a frame accepted
	logic   sum_ok;		// checksum byte agrees with the sum
	byte_t  rep_status;	// status of the pending reply
	word_t  rep_value;	// value of the pending reply
	logic   rep_pending;	// reply fields not yet taken by sender
	logic   form_q;		// link form seen in the previous cycle
	logic   to_reply;	// this edge moves into the reply state

	reply_if rep ();	// hand-over to the reply sender

	// the bus is half duplex: accept bytes only while listening
	assign rx_ready   = (state == S_RECV);
	assign rx_take    = rx_valid && rx_ready;
	assign first_idx  = can_mode ? CMD_IDX_CODE : CMD_IDX_ADDR;
	assign last_idx   = can_mode ? CMD_IDX_VAL_LSB : CMD_IDX_SUM;
	assign frame_end  = rx_take && (idx == last_idx);
	assign sum_ok     = (rx_data == sum);
	assign exec_valid = (state == S_EXEC);
	// the two ways into the reply state: executor done, or checksum failed
	assign to_reply   = (state == S_WAIT && result_valid)
		|| (state == S_RECV && frame_end && !can_mode
		&& addr_hit && !sum_ok);

	// byte position counter; restarts after each frame
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			idx <= IDX_RESET;
		end else if (state != S_RECV) begin
			idx <= first_idx;
		end else if (rx_take) begin
			idx <= frame_end ? first_idx : idx + 4'h1;
		end else if (can_mode != form_q) begin
			idx <= first_idx;	// form changed while idle
		end
	end

	// remembers the link form so a change between frames restarts the count;
	// without it a return to the long form would skip the address byte
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			form_q <= 1'b0;
		end else begin
			form_q <= can_mode;
		end
	end

	// field capture by byte position
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			exec_code  <= BYTE_RESET;
			exec_type  <= BYTE_RESET;
			exec_bank  <= BYTE_RESET;
			exec_value <= WORD_RESET;
			addr_hit   <= 1'b0;
		end else if (rx_take) begin
			case (idx)
				CMD_IDX_ADDR: begin
					addr_hit <= (rx_data == module_address);
				end
				CMD_IDX_CODE: begin
					exec_code <= rx_data;
				end
				CMD_IDX_TYPE: begin
					exec_type <= rx_data;
				end
				CMD_IDX_BANK: begin
					exec_bank <= rx_data;
				end
				CMD_IDX_SUM: begin
					// checksum is compared, not stored
				end
				default: begin	// value bytes, most significant first
					exec_value <= {exec_value[23:0], rx_data};
				end
			endcase
		end
	end

	// running checksum; the address byte is included
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sum <= BYTE_RESET;
		end else if (rx_take) begin
			sum <= (idx == first_idx) ? rx_data : sum + rx_data;
		end
	end

	// frame and reply sequencer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= S_RECV;
		end else begin
			case (state)
				S_RECV: begin
					if (frame_end) begin
						if (can_mode) begin	// hardware CRC already checked
							state <= S_EXEC;
						end else if (!addr_hit) begin
							// not for us: stay silent
							state <= S_RECV;
						end else if (sum_ok) begin
							state <= S_EXEC;
						end else begin
							state <= S_REPLY;
						end
					end
				end
				S_EXEC: begin
					if (exec_ready) begin
						state <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (result_valid) begin
						state <= S_REPLY;
					end
				end
				S_REPLY: begin
					if (rep.done) begin	// reply left: listen again
						state <= S_RECV;
					end
				end
				default: begin
					state <= S_RECV;
				end
			endcase
		end
	end

	// reply contents: executor result, or checksum error without execution
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rep_status <= STATUS_OK;
			rep_value  <= WORD_RESET;
		end else if (state == S_RECV && frame_end) begin
			rep_status <= STATUS_BAD_SUM;
			rep_value  <= WORD_RESET;
		end else if (state == S_WAIT && result_valid) begin
			rep_status <= result_status;
			rep_value  <= result_value;
		end
	end

	// offer the reply once: raised on the move into the reply state and
	// dropped when the sender takes it, so no reply is ever offered twice
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rep_pending <= 1'b0;
		end else if (to_reply) begin
			rep_pending <= 1'b1;
		end else if (rep.ready) begin
			rep_pending <= 1'b0;
		end
	end

	assign rep.valid          = rep_pending;
	assign rep.can_mode       = can_mode;
	assign rep.reply_address  = reply_address;
	assign rep.module_address = module_address;
	assign rep.status         = rep_status;
	assign rep.code           = exec_code;
	assign rep.value          = rep_value;

	// the sender owns the outgoing byte stream and the driver enable
	reply_sender sender (
		.clock    (clock),
		.nrst     (nrst),
		.rep      (rep),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.tx_ready (tx_ready),
		.tx_last  (tx_last),
		.tx_drive (tx_drive)
	);

	// command side: the port closes, fields land where the frame puts them
	a_rx_closed_busy: assert property (@(posedge clock)
		disable iff (!nrst)
		frame_end && (can_mode || addr_hit) |=> !rx_ready)
		else $error("bus still open after a command frame");
	a_code_capture: assert property (@(posedge clock)
		disable iff (!nrst)
		rx_take && idx == CMD_IDX_CODE |=> exec_code == $past(rx_data))
		else $error("command code byte not captured");
	a_type_capture: assert property (@(posedge clock)
		disable iff (!nrst)
		rx_take && idx == CMD_IDX_TYPE |=> exec_type == $past(rx_data))
		else $error("type byte not captured");
	a_bank_capture: assert property (@(posedge clock)
		disable iff (!nrst)
		rx_take && idx == CMD_IDX_BANK |=> exec_bank == $past(rx_data))
		else $error("motor or bank byte not captured");
	a_exec_hold: assert property (@(posedge clock)
		disable iff (!nrst)
		exec_valid && !exec_ready
		|=> exec_valid && $stable(exec_code) && $stable(exec_value))
		else $error("command fields changed while offered");
	a_frame_restart: assert property (@(posedge clock)
		disable iff (!nrst)
		frame_end |=> idx == $past(first_idx))
		else $error("byte counter did not restart after a frame");
	a_good_frame_exec: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_RECV && frame_end && !can_mode && addr_hit && sum_ok
		|=> exec_valid)
		else $error("good frame not offered to the executor");
	a_addr_compare: assert property (@(posedge clock)
		disable iff (!nrst)
		rx_take && idx == CMD_IDX_ADDR
		|=> addr_hit == ($past(rx_data) == $past(module_address)))
		else $error("address byte not compared with our address");
	a_value_msb_first: assert property (@(posedge clock)
		disable iff (!nrst)
		rx_take && idx == CMD_IDX_VAL_LSB
		|=> exec_value[7:0] == $past(rx_data))
		else $error("last value byte is not the least significant");
	a_sum_first_byte: assert property (@(posedge clock)
		disable iff (!nrst)
		rx_take && idx == first_idx |=> sum == $past(rx_data))
		else $error("checksum does not restart at the first byte");
	a_bad_sum_reply: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_RECV && frame_end && !can_mode && addr_hit && !sum_ok
		|=> state == S_REPLY && rep_status == STATUS_BAD_SUM)
		else $error("bad checksum not answered with status 1");
	a_short_no_check: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_RECV && frame_end && can_mode |=> state == S_EXEC)
		else $error("short frame not offered to the executor");
	// reply side: one reply per command, and only then the bus
	a_foreign_silent: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_RECV && frame_end && !can_mode && !addr_hit
		|=> state == S_RECV [*2])
		else $error("frame for another address was answered");
	a_reply_on_result: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_WAIT && result_valid |=> rep.valid && state == S_REPLY)
		else $error("executor result not turned into a reply");
	a_one_reply: assert property (@(posedge clock)
		disable iff (!nrst)
		rep.ready |=> !rep.valid && state == S_REPLY)
		else $error("reply handed to the sender more than once");
	a_drive_only_reply: assert property (@(posedge clock)
		disable iff (!nrst)
		tx_drive |-> state == S_REPLY)
		else $error("bus driven outside a reply");
	a_listen_after_reply: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_REPLY && rep.done |=> rx_ready && !tx_drive)
		else $error("bus not released after the reply");
	a_result_status: assert property (@(posedge clock)
		disable iff (!nrst)
		state == S_WAIT && result_valid
		|=> rep_status == $past(result_status)
		&& rep_value == $past(result_value))
		else $error("reply does not carry the executor result");
	a_reply_echo_code: assert property (@(posedge clock)
		disable iff (!nrst)
		rep.valid |-> rep.code == exec_code && state == S_REPLY)
		else $error("reply does not echo the command code");
endmodule : cmd_frame_parser
`default_nettype wire

/* shared/frame_pkg.sv */
// constants and types shared by the command frame parser and reply sender
package frame_pkg;
	typedef logic [7:0]  byte_t;	// one frame byte
	typedef logic [31:0] word_t;	// four-byte value field
	typedef logic [3:0]  idx_t;	// byte position within a frame

	// command frame byte positions (serial form, address first)
	localparam idx_t CMD_IDX_ADDR    = 4'h0;
	localparam idx_t CMD_IDX_CODE    = 4'h1;
	localparam idx_t CMD_IDX_TYPE    = 4'h2;
	localparam idx_t CMD_IDX_BANK    = 4'h3;
	localparam idx_t CMD_IDX_VAL_MSB = 4'h4;
	localparam idx_t CMD_IDX_VAL_LSB = 4'h7;
	localparam idx_t CMD_IDX_SUM     = 4'h8;

	// reply frame byte positions (serial form)
	localparam idx_t REP_IDX_RADDR   = 4'h0;
	localparam idx_t REP_IDX_MADDR   = 4'h1;
	localparam idx_t REP_IDX_STATUS  = 4'h2;
	localparam idx_t REP_IDX_CODE    = 4'h3;
	localparam idx_t REP_IDX_VAL_MSB = 4'h4;
	localparam idx_t REP_IDX_VAL_LSB = 4'h7;
	localparam idx_t REP_IDX_SUM     = 4'h8;

	// reply status codes
	localparam byte_t STATUS_OK        = 8'h64;	// 100
	localparam byte_t STATUS_STORED    = 8'h65;	// 101
	localparam byte_t STATUS_BAD_SUM   = 8'h01;
	localparam byte_t STATUS_BAD_CMD   = 8'h02;
	localparam byte_t STATUS_BAD_TYPE  = 8'h03;
	localparam byte_t STATUS_BAD_VALUE = 8'h04;
	localparam byte_t STATUS_LOCKED    = 8'h05;
	localparam byte_t STATUS_UNAVAIL   = 8'h06;

	// reset values
	localparam byte_t BYTE_RESET = 8'h00;
	localparam word_t WORD_RESET = 32'h0000_0000;
	localparam idx_t  IDX_RESET  = 4'h0;
endpackage : frame_pkg

/* shared/reply_if.sv */
// reply hand-over between the command parser and the reply sender
`timescale 1ns/1ns
`default_nettype none
interface reply_if;
	import frame_pkg::*;
	logic  valid;		// reply fields are ready to send
	logic  ready;		// sender takes the fields this cycle
	logic  done;		// last reply byte left the sender
	logic  can_mode;	// short form: no addresses, no checksum
	byte_t reply_address;	// address the host listens on
	byte_t module_address;	// our own address
	byte_t status;		// reply status code
	byte_t code;		// echoed command code
	word_t value;		// reply value

	modport src (output valid, can_mode, reply_address, module_address,
		status, code, value, input ready, done);
	modport sink (input valid, can_mode, reply_address, module_address,
		status, code, value, output ready, done);
endinterface : reply_if
`default_nettype wire

/* hdl/reply_sender.sv */
// serialises one reply frame onto the outgoing byte stream
`timescale 1ns/1ns
`default_nettype none
module reply_sender
	import frame_pkg::*;
(
	input  wire logic  clock,	// system clock
	input  wire logic  nrst,	// async reset, active low
	reply_if.sink      rep,		// fields from the parser
	output logic       tx_valid,	// byte on tx_data is valid
	output byte_t      tx_data,	// outgoing byte
	input  wire logic  tx_ready,	// link takes the byte
	output logic       tx_last,	// final byte of the reply
	output logic       tx_drive	// bus driver enable
);
	byte_t frame [0:8];	// latched reply bytes
	byte_t built [0:8];	// reply bytes assembled from the fields
	logic  sending;		// a reply is on its way
	logic  short_form;	// latched can_mode of this reply
	idx_t  idx;		// position of the byte on tx_data
	idx_t  last_idx;	// final position for this form
	byte_t sent_sum;	// sum of bytes already sent, checker only
	logic  done_q;		// end-of-reply pulse

	// assemble the reply; checksum covers every other byte
	always_comb begin
		built[REP_IDX_RADDR]  = rep.reply_address;
		built[REP_IDX_MADDR]  = rep.module_address;
		built[REP_IDX_STATUS] = rep.status;
		built[REP_IDX_CODE]   = rep.code;
		for (int i = 0; i < 4; i++) begin
			built[REP_IDX_VAL_MSB + i] = rep.value[31 - 8 * i -: 8];
		end
		built[REP_IDX_SUM] = BYTE_RESET;
		for (int i = 0; i < 8; i++) begin
			built[REP_IDX_SUM] = built[REP_IDX_SUM] + built[i];
		end
	end

	// only take new fields while idle, so one reply never overlaps another
	assign rep.ready = rep.valid && !sending;
	assign rep.done  = done_q;
	assign tx_valid  = sending;
	assign tx_drive  = sending;
	// short form drops the two address bytes and the checksum
	assign last_idx  = short_form ? REP_IDX_VAL_LSB : REP_IDX_SUM;
	assign tx_last   = sending && (idx == last_idx);

	// byte sequencer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sending    <= 1'b0;
			short_form <= 1'b0;
			idx        <= IDX_RESET;
			tx_data    <= BYTE_RESET;
			done_q     <= 1'b0;
			for (int i = 0; i < 9; i++) begin
				frame[i] <= BYTE_RESET;
			end
		end else begin
			done_q <= 1'b0;
			if (rep.ready) begin	// load a reply
				sending    <= 1'b1;
				short_form <= rep.can_mode;
				for (int i = 0; i < 9; i++) begin
					frame[i] <= built[i];
				end
				idx     <= rep.can_mode ? REP_IDX_STATUS : REP_IDX_RADDR;
				tx_data <= rep.can_mode ? built[REP_IDX_STATUS]
					: built[REP_IDX_RADDR];
			end else if (sending && tx_ready) begin
				if (idx == last_idx) begin	// back to receive mode
					sending <= 1'b0;
					done_q  <= 1'b1;
				end else begin
					idx     <= idx + 4'h1;
					tx_data <= frame[idx + 4'h1];
				end
			end
		end
	end

	// running sum of sent bytes, read only by the checks
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sent_sum <= BYTE_RESET;
		end else if (rep.ready) begin
			sent_sum <= BYTE_RESET;
		end else if (sending && tx_ready) begin
			sent_sum <= sent_sum + tx_data;
		end
	end

	a_tx_checksum: assert property (@(posedge clock)
		disable iff (!nrst)
		tx_last && !short_form |-> tx_data == sent_sum)
		else $error("reply checksum is not the sum of the other bytes");
	a_tx_first_byte: assert property (@(posedge clock)
		disable iff (!nrst)
		rep.ready && !rep.can_mode |=> tx_data == $past(rep.reply_address))
		else $error("serial reply does not open with reply address");
	a_tx_short_form: assert property (@(posedge clock)
		disable iff (!nrst)
		rep.ready && rep.can_mode |=> tx_data == $past(rep.status))
		else $error("short reply does not open with status");
endmodule : reply_sender
`default_nettype wire

/* testbench/host_model.sv */
// host-side model: offers command frames and collects reply bytes
`timescale 1ns/1ns
`default_nettype none
module host_model
	import frame_pkg::*;
(
	input  wire logic  clock,	// system clock
	output logic       rx_valid,	// command byte offered
	output byte_t      rx_data,	// command byte
	input  wire logic  rx_ready,	// block takes the byte
	input  wire logic  tx_valid,	// reply byte present
	input  wire byte_t tx_data,	// reply byte
	output logic       tx_ready,	// host takes the reply byte
	input  wire logic  tx_last,	// final reply byte
	input  wire logic  tx_drive	// block drives the bus
);
	// idle host: nothing offered, not yet listening
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
	end

	// offer n bytes in frame order, gap idle cycles after each one
	task automatic send(input byte_t f [9], input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			rx_data  <= f[i];
			@(negedge clock);
			while (rx_ready !== 1'b1) @(negedge clock);
			@(posedge clock);
			// keep valid up between back-to-back bytes
			if (gap > 0 || i == n - 1) begin
				rx_valid <= 1'b0;
				rx_data  <= ~f[i];	// released line shows no stale byte
				repeat (gap) @(posedge clock);
			end
		end
	endtask : send

	// take n reply bytes, stalling stall cycles after each one
	task automatic recv(output byte_t r [9], output logic [8:0] last,
		output logic drv, input int n, input int stall);
		drv  = 1'b1;
		last = 9'h000;
		for (int i = 0; i < n; i++) begin
			tx_ready <= 1'b1;
			@(negedge clock);
			while (tx_valid !== 1'b1) @(negedge clock);
			r[i]    = tx_data;
			last[i] = tx_last;
			drv     = drv & (tx_drive === 1'b1);
			@(posedge clock);
			if (stall > 0 || i == n - 1) begin
				tx_ready <= 1'b0;	// slow host holds the block off
				repeat (stall) @(posedge clock);
			end
		end
	endtask : recv
endmodule : host_model
`default_nettype wire

/* testbench/motion_cmd_frame_parser_bench.sv */
// self-checking bench for the command frame parser
`timescale 1ns/1ns
`default_nettype none
module motion_cmd_frame_parser_bench
	import frame_pkg::*;
;
	logic  clock, nrst, can_mode;	// clock, reset, short form
	byte_t module_address;		// our address
	byte_t reply_address;		// host listens here
	logic  rx_valid, rx_ready;	// command byte handshake
	byte_t rx_data;			// command byte
	logic  exec_valid, exec_ready;	// executor handshake
	byte_t exec_code, exec_type;	// command fields
	byte_t exec_bank;		// motor or bank field
	word_t exec_value;		// value field
	logic  result_valid;		// executor finished
	byte_t result_status;		// status to report
	word_t result_value;		// value to report
	logic  tx_valid, tx_ready;	// reply byte handshake
	byte_t tx_data;			// reply byte
	logic  tx_last, tx_drive;	// final byte, bus enable
	int    fails, n_checks;		// verdict counters

	cmd_frame_parser i_dut (.clock(clock), .nrst(nrst),
		.can_mode(can_mode), .module_address(module_address),
		.reply_address(reply_address), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready),
		.exec_valid(exec_valid), .exec_code(exec_code),
		.exec_type(exec_type), .exec_bank(exec_bank),
		.exec_value(exec_value), .exec_ready(exec_ready),
		.result_valid(result_valid), .result_status(result_status),
		.result_value(result_value), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_last(tx_last),
		.tx_drive(tx_drive));

	host_model host (.clock(clock), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_last(tx_last),
		.tx_drive(tx_drive));

	// compare one value and count it
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// verdict and end of run
	task automatic results();
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// one exchange; err spoils the checksum, wrong addr gets no reply in the long form
	task automatic run_cmd(input byte_t addr, code, typ, bank,
		input word_t val, input byte_t err, st, input word_t rv,
		input int stall);
		byte_t c [9];
		byte_t f [9];
		byte_t e [9];
		byte_t r [9];
		logic [8:0] last;
		logic drv;
		byte_t s;
		int k, o, n;
		c[0] = addr;
		c[1] = code;
		c[2] = typ;
		c[3] = bank;
		{c[4], c[5], c[6], c[7]} = val;
		s = 8'h00;
		for (k = 0; k < 8; k++) s = s + c[k];
		c[8] = s + err;
		o = can_mode ? 1 : 0;
		n = can_mode ? 7 : 9;
		for (k = 0; k < n; k++) f[k] = c[k + o];
		host.send(f, n, stall);
		if (!can_mode && addr !== module_address) begin
			// foreign frame: silence, keep listening
			repeat (20) begin
				@(negedge clock);
				check("tx_drive", 0, tx_drive);
				check("rx_ready", 1, rx_ready);
			end
			@(posedge clock);
			return;
		end
		if (!can_mode && err != 8'h00) begin
			st = STATUS_BAD_SUM;
			rv = 32'h0000_0000;
		end else begin
			k = 0;
			@(negedge clock);
			while (exec_valid !== 1'b1 && k < 50) begin
				@(negedge clock);
				k++;
			end
			check("exec_valid", 1, exec_valid);
			check("exec_code", code, exec_code);
			check("exec_type", typ, exec_type);
			check("exec_bank", bank, exec_bank);
			check("exec_value", val, exec_value);
			@(posedge clock);
			exec_ready <= 1'b1;
			@(posedge clock);
			exec_ready <= 1'b0;
			repeat (2) @(posedge clock);
			result_valid  <= 1'b1;
			result_status <= st;
			result_value  <= rv;
			@(posedge clock);
			result_valid <= 1'b0;
		end
		e[0] = reply_address;
		e[1] = module_address;
		e[2] = st;
		e[3] = code;
		{e[4], e[5], e[6], e[7]} = rv;
		s = 8'h00;
		for (k = 0; k < 8; k++) s = s + e[k];
		e[8] = s;
		o = can_mode ? 2 : 0;
		n = can_mode ? 6 : 9;
		host.recv(r, last, drv, n, stall);
		for (k = 0; k < n; k++)
			check("reply byte", e[k + o], r[k]);
		check("tx_last", 9'h001 << (n - 1), last);
		check("tx_drive in reply", 1, drv);
		// one reply only, then back to listening
		repeat (10) begin
			@(negedge clock);
			check("tx_drive", 0, tx_drive);
			check("exec_valid", 0, exec_valid);
			check("tx_valid", 0, tx_valid);
		end
		check("rx_ready", 1, rx_ready);
		@(posedge clock);
	endtask : run_cmd

	// every status code back to back, host stall cycling through 0, 1 and 2
	task automatic t_status_codes();
		byte_t sc [8];
		sc = '{STATUS_OK, STATUS_STORED, STATUS_BAD_SUM, STATUS_BAD_CMD,
			STATUS_BAD_TYPE, STATUS_BAD_VALUE, STATUS_LOCKED,
			STATUS_UNAVAIL};
		for (int i = 0; i < 8; i++)
			run_cmd(module_address, 8'h05 + 8'(i), 8'h2c, 8'h01,
				32'h8123_45fe, 8'h00, sc[i], 32'hfedc_0a01 + i,
				i % 3);
	endtask : t_status_codes

	// corrupt checksum with a wrapping sum
	task automatic t_bad_sum();
		run_cmd(module_address, 8'hff, 8'hff, 8'hff, 32'hffff_ffff,
			8'h01, STATUS_OK, 32'h1, 1);
	endtask : t_bad_sum

	// frame for another module, then a good one
	task automatic t_wrong_addr();
		run_cmd(module_address + 8'h01, 8'h06, 8'h00, 8'h00, 32'h0,
			8'h00, STATUS_OK, 32'h0, 0);
		run_cmd(module_address, 8'h06, 8'h01, 8'h00, 32'h0,
			8'h00, STATUS_OK, 32'h7fff_ffff, 0);
	endtask : t_wrong_addr

	// short form: no address, no checksum either way
	task automatic t_short_form();
		can_mode <= 1'b1;
		@(posedge clock);
		run_cmd(8'h00, 8'h04, 8'h01, 8'h02, 32'h0001_0203,
			8'h00, STATUS_OK, 32'ha5b6_c7d8, 2);
		can_mode <= 1'b0;
		@(posedge clock);
		// back on the long form the address byte must count again
		run_cmd(module_address, 8'h0a, 8'h03, 8'h00, 32'h0000_0100,
			8'h00, STATUS_OK, 32'h0000_0005, 1);
	endtask : t_short_form

	// free-running system clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// reset, then every scenario in turn
	initial begin
		nrst = 1'b0;
		can_mode = 1'b0;
		module_address = 8'h2a;
		reply_address = 8'h02;
		exec_ready = 1'b0;
		result_valid = 1'b0;
		result_status = 8'h00;
		result_value = 32'h0;
		fails = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		check("tx_drive in reset", 0, tx_drive);
		nrst <= 1'b1;
		@(posedge clock);
		t_status_codes();
		t_bad_sum();
		t_wrong_addr();
		t_short_form();
		results();
	end

	// a hang counts as a failure
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		results();
	end
endmodule : motion_cmd_frame_parser_bench
`default_nettype wire
